// File: hw/acp_config_port.sv
// Serial configuration port with power-down and reference control.
// Assumes shiftClk runs only during frames; sys_clk is free running.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
module acp_config_port #(
	parameter int REF_WAKE_CYCLES = acp_pkg::REF_WAKE_CYC
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic              clkEn,
	input  wire logic [7:0]        regAddr,
	input  wire logic [31:0]       regWrData,
	input  wire logic              regWr,
	input  wire logic              regRd,
	output logic      [31:0]       regRdData,
	input  wire logic              shiftClk,
	input  wire logic              serialSelectN,
	input  wire logic              serialDataIn,
	output logic                   serialDataOut,
	output logic                   serialDataOe,
	input  wire logic              powerdownSyncPin,
	input  wire logic [1:0]        referenceStrapPin,
	input  wire logic              sampleClkRunning,
	output acp_pkg::acpPower_t     powerState,
	output acp_pkg::acpMode_t      modeState
);

	// Link domain state
	logic [4:0]           bitCnt_q;
	logic [22:0]          shift_q;
	logic                 hdrRead_q;
	logic [11:0]          hdrAddr_q;
	acp_pkg::acpPdn_t     pdnL_q;
	acp_pkg::acpRef_t     refL_q;
	acp_pkg::acpFmt_t     fmtL_q;
	logic                 commitTgl_q;
	logic [7:0]           rdByte;
	logic [7:0]           wrByte;
	logic [2:0]           rdIdx;

	// System domain state
	logic [1:0]           pinSync_q;
	logic [1:0]           runSync_q;
	logic [1:0]           strapS0_q;
	logic [1:0]           strapS1_q;
	logic [2:0]           tglSync_q;
	acp_pkg::acpPdn_t     pdn_q;
	acp_pkg::acpRef_t     ref_q;
	acp_pkg::acpFmt_t     fmt_q;
	logic [31:0]          ctrl_q;
	logic [15:0]          frames_q;
	logic [1:0]           strapCnt_q;
	logic [1:0]           strap_q;
	logic                 strapValid_q;
	logic                 adcOff_q;
	logic                 refOff_q;
	logic                 refAmpOff_q;
	logic                 clkBufOff_q;
	logic                 refOff_d;
	logic [31:0]          wakeCnt_q;
	logic                 refReady_q;
	logic                 globalReq;
	logic                 strapInternal;
	logic                 refInternal;
	logic                 commitSeen;
	logic [31:0]          status;
	logic [31:0]          rdData_q;

	assign wrByte = {shift_q[6:0], serialDataIn};
	assign rdIdx  = 3'(5'd23 - bitCnt_q);

	// Bit counter and shifter; select high clears the counter and read flag, not the shifter
	always_ff @(posedge shiftClk or negedge resetn or posedge serialSelectN) begin
		if (!resetn) begin
			bitCnt_q  <= 5'h00;
			shift_q   <= 23'h000000;
			hdrRead_q <= 1'b0;
			hdrAddr_q <= 12'h000;
		end else if (serialSelectN) begin
			bitCnt_q  <= 5'h00;
			hdrRead_q <= 1'b0;
		end else begin
			shift_q <= {shift_q[21:0], serialDataIn};
			if (bitCnt_q == acp_pkg::CNT_FRAME_LAST) begin
				bitCnt_q <= 5'h00;
			end else begin
				bitCnt_q <= bitCnt_q + 5'h01;
			end
			if (bitCnt_q == acp_pkg::CNT_HDR_LAST) begin
				hdrRead_q <= shift_q[14];
				hdrAddr_q <= {shift_q[10:0], serialDataIn};
			end
		end
	end

	// Configuration registers, written on the 24th edge of a write frame
	always_ff @(posedge shiftClk or negedge resetn) begin
		if (!resetn) begin
			pdnL_q      <= acp_pkg::PDN_RST;
			refL_q      <= acp_pkg::REF_RST;
			fmtL_q      <= acp_pkg::FMT_RST;
			commitTgl_q <= 1'b0;
		end else if (!serialSelectN && bitCnt_q == acp_pkg::CNT_FRAME_LAST
			&& !hdrRead_q) begin
			commitTgl_q <= ~commitTgl_q;
			unique case (hdrAddr_q)
				acp_pkg::SA_PDN: pdnL_q <= wrByte;
				acp_pkg::SA_REF: refL_q <= wrByte;
				acp_pkg::SA_FMT: fmtL_q <= wrByte;
				default: begin
				end
			endcase
		end
	end

	always_comb begin
		unique case (hdrAddr_q)
			acp_pkg::SA_PDN: rdByte = pdnL_q;
			acp_pkg::SA_REF: rdByte = refL_q;
			acp_pkg::SA_FMT: rdByte = fmtL_q;
			default:         rdByte = 8'h00;
		endcase
	end

	// Read data launched on falling edges after the header
	always_ff @(negedge shiftClk or negedge resetn or posedge serialSelectN) begin
		if (!resetn) begin
			serialDataOut <= 1'b0;
			serialDataOe  <= 1'b0;
		end else if (serialSelectN) begin
			serialDataOut <= 1'b0;
			serialDataOe  <= 1'b0;
		end else if (hdrRead_q && bitCnt_q >= 5'(acp_pkg::HDR_BITS)) begin
			serialDataOut <= rdByte[rdIdx];
			serialDataOe  <= 1'b1;
		end else begin
			serialDataOut <= 1'b0;
			serialDataOe  <= 1'b0;
		end
	end

	// Synchronisers for pins and the commit toggle
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pinSync_q <= 2'h0;
			runSync_q <= 2'h0;
			strapS0_q <= 2'h0;
			strapS1_q <= 2'h0;
			tglSync_q <= 3'h0;
		end else if (clkEn) begin
			pinSync_q <= {pinSync_q[0], powerdownSyncPin};
			runSync_q <= {runSync_q[0], sampleClkRunning};
			strapS0_q <= referenceStrapPin;
			strapS1_q <= strapS0_q;
			tglSync_q <= {tglSync_q[1:0], commitTgl_q};
		end
	end

	assign commitSeen = tglSync_q[2] ^ tglSync_q[1];

	// Mirror of the serial registers; source is stable between frames
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			pdn_q    <= acp_pkg::PDN_RST;
			ref_q    <= acp_pkg::REF_RST;
			fmt_q    <= acp_pkg::FMT_RST;
			frames_q <= 16'h0000;
		end else if (clkEn && commitSeen) begin
			pdn_q    <= pdnL_q;
			ref_q    <= refL_q;
			fmt_q    <= fmtL_q;
			frames_q <= frames_q + 16'h0001;
		end
	end

	// Strap caught once after reset, when the synchroniser has settled
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			strapCnt_q   <= 2'h0;
			strap_q      <= acp_pkg::STRAP_HIGH;
			strapValid_q <= 1'b0;
		end else if (clkEn && !strapValid_q) begin
			if (strapCnt_q == acp_pkg::STRAP_SETTLE) begin
				strap_q      <= strapS1_q;
				strapValid_q <= 1'b1;
			end else begin
				strapCnt_q <= strapCnt_q + 2'h1;
			end
		end
	end

	assign strapInternal = strap_q == acp_pkg::STRAP_INT
		|| strap_q == acp_pkg::STRAP_LOW;
	assign refInternal = ref_q.overrideStrap ? ref_q.selInternal
		: strapInternal;
	assign globalReq = pinSync_q[1] | pdn_q.global | ctrl_q[0];
	assign refOff_d = (globalReq & ~ref_q.maskFromGlobal)
		| ~refInternal;

	// Power state moves only while the sampling clock runs
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			adcOff_q    <= 1'b0;
			refOff_q    <= 1'b1;
			refAmpOff_q <= 1'b0;
			clkBufOff_q <= 1'b0;
		end else if (clkEn && runSync_q[1]) begin
			adcOff_q    <= globalReq | pdn_q.adc;
			refOff_q    <= refOff_d;
			refAmpOff_q <= pdn_q.refAmp;
			clkBufOff_q <= pdn_q.clkBuf;
		end
	end

	// Internal reference wake-up time
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			wakeCnt_q  <= 32'h0000_0000;
			refReady_q <= 1'b0;
		end else if (clkEn) begin
			if (refOff_q) begin
				wakeCnt_q  <= 32'(REF_WAKE_CYCLES);
				refReady_q <= 1'b0;
			end else if (wakeCnt_q != 32'h0000_0000) begin
				wakeCnt_q  <= wakeCnt_q - 32'h0000_0001;
				refReady_q <= 1'b0;
			end else begin
				refReady_q <= 1'b1;
			end
		end
	end

	// Local register bus
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_q <= acp_pkg::CTRL_RST;
		end else if (clkEn && regWr && regAddr == acp_pkg::LA_CTRL) begin
			ctrl_q <= {31'h00000000, regWrData[0]};
		end
	end

	assign status = {24'h000000, strap_q, runSync_q[1], refReady_q,
		clkBufOff_q, refAmpOff_q, refOff_q, adcOff_q};

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rdData_q <= 32'h0000_0000;
		end else if (clkEn) begin
			if (regRd) begin
				unique case (regAddr)
					acp_pkg::LA_CTRL:   rdData_q <= ctrl_q;
					acp_pkg::LA_STATUS: rdData_q <= status;
					acp_pkg::LA_PDN:    rdData_q <= {24'h000000, pdn_q};
					acp_pkg::LA_REF:    rdData_q <= {24'h000000, ref_q};
					acp_pkg::LA_FMT:    rdData_q <= {24'h000000, fmt_q};
					acp_pkg::LA_FRAMES: rdData_q <= {16'h0000, frames_q};
					default:            rdData_q <= 32'h0000_0000;
				endcase
			end else begin
				rdData_q <= 32'h0000_0000;
			end
		end
	end

	assign regRdData = rdData_q;

	assign powerState = '{adcOff: adcOff_q, refOff: refOff_q,
		refAmpOff: refAmpOff_q, clkBufOff: clkBufOff_q,
		refReady: refReady_q};

	// Modes from strap, reference and format registers
	assign modeState = '{refInternal: refInternal,
		refGainBuf: strap_q == acp_pkg::STRAP_BUF && !ref_q.overrideStrap,
		clkSingleEnded: strap_q == acp_pkg::STRAP_LOW,
		serial2Wire: strap_q == acp_pkg::STRAP_LOW,
		ddcBypass: !fmt_q.ddcEnable,
		ddrOut: fmt_q.ddrOut,
		offsetBinary: fmt_q.offsetBinary};

endmodule

// File: hw/acp_pkg.sv
// Constants, field layouts and carrier types of the ADC configuration port.
// Assumes a 50 MHz system clock and 8-bit serial configuration registers.
package acp_pkg;

	// Serial frame layout
	localparam int FRAME_BITS = 24;
	localparam int HDR_BITS   = 16;
	localparam int DATA_BITS  = 8;
	localparam int ADDR_BITS  = 12;
	localparam logic [4:0] CNT_HDR_LAST   = 5'h0f;
	localparam logic [4:0] CNT_FRAME_LAST = 5'h17;

	// Serial register addresses
	localparam logic [11:0] SA_PDN = 12'h008;
	localparam logic [11:0] SA_REF = 12'h00d;
	localparam logic [11:0] SA_FMT = 12'h00e;

	// Local bus byte addresses
	localparam logic [7:0] LA_CTRL   = 8'h00;
	localparam logic [7:0] LA_STATUS = 8'h04;
	localparam logic [7:0] LA_PDN    = 8'h08;
	localparam logic [7:0] LA_REF    = 8'h0c;
	localparam logic [7:0] LA_FMT    = 8'h10;
	localparam logic [7:0] LA_FRAMES = 8'h14;

	// Strap comparator codes
	localparam logic [1:0] STRAP_LOW  = 2'h0;
	localparam logic [1:0] STRAP_INT  = 2'h1;
	localparam logic [1:0] STRAP_BUF  = 2'h2;
	localparam logic [1:0] STRAP_HIGH = 2'h3;

	// Timing
	localparam int REF_WAKE_MS = 3;
	localparam int SYS_CLK_HZ  = 50_000_000;
	localparam int REF_WAKE_CYC = REF_WAKE_MS * (SYS_CLK_HZ / 1000);
	localparam logic [1:0] STRAP_SETTLE = 2'h2;

	typedef struct packed {
		logic [1:0] rsvdHi;
		logic       clkBuf;
		logic       refAmp;
		logic       rsvdMid;
		logic       adc;
		logic       rsvdLo;
		logic       global;
	} acpPdn_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       maskFromGlobal;
		logic       overrideStrap;
		logic       selInternal;
	} acpRef_t;

	typedef struct packed {
		logic [4:0] rsvd;
		logic       offsetBinary;
		logic       ddrOut;
		logic       ddcEnable;
	} acpFmt_t;

	localparam acpPdn_t PDN_RST = 8'h00;
	localparam acpRef_t REF_RST = 8'h00;
	localparam acpFmt_t FMT_RST = 8'h00;
	localparam logic [31:0] CTRL_RST = 32'h0000_0000;

	typedef struct packed {
		logic adcOff;
		logic refOff;
		logic refAmpOff;
		logic clkBufOff;
		logic refReady;
	} acpPower_t;

	typedef struct packed {
		logic refInternal;
		logic refGainBuf;
		logic clkSingleEnded;
		logic serial2Wire;
		logic ddcBypass;
		logic ddrOut;
		logic offsetBinary;
	} acpMode_t;

endpackage

// File: verif/acp_host_model.sv
// Serial host model: select, shift clock and the shared data pin.
// Assumes the bench calls xfer between bus cycles.
`timescale 1ns/1ps
module acp_host_model (
	input  logic serialDataOut,
	input  logic serialDataOe,
	output logic shiftClk,
	output logic serialSelectN,
	output logic serialDataIn
);
	logic hostBit = 1'b0;
	logic hostOe  = 1'b0;
	logic pinLast = 1'b0;
	initial begin
		shiftClk = 1'b0;
		serialSelectN = 1'b1;
	end
	// Pin has no pull: undriven it shows the inverse of the last bit
	always_comb serialDataIn = serialDataOe ? serialDataOut :
		hostOe ? hostBit : ~pinLast;
	always @(posedge shiftClk) pinLast <= serialDataIn;
	task automatic xfer(input logic [47:0] w, input int n,
		output logic [7:0] r);
		logic rd;
		int   p;
		rd = 1'b0;
		r = 8'h00;
		serialSelectN = 1'b0;
		for (int i = n - 1; i >= 0; i--) begin
			p = (n - 1 - i) % 24;
			if (p == 0)
				rd = w[i];
			hostBit = w[i];
			hostOe = !(rd && p >= 16);
			#9 shiftClk = 1'b1;
			if (rd && p >= 16)
				r = {r[6:0], serialDataIn};
			#6 shiftClk = 1'b0;
		end
		#9 serialSelectN = 1'b1;
		hostOe = 1'b0;
	endtask
endmodule

// File: verif/acp_config_port_chk.sv
// Assertions on the configuration port, bound to its ports.
// Assumes the shift clock idles low outside frames.
`timescale 1ns/1ps
module acp_config_port_chk #(
	parameter int REF_WAKE_CYCLES = acp_pkg::REF_WAKE_CYC
) (
	input wire logic               sys_clk,
	input wire logic               resetn,
	input wire logic               shiftClk,
	input wire logic               serialSelectN,
	input wire logic               serialDataIn,
	input wire logic               serialDataOe,
	input wire logic               powerdownSyncPin,
	input wire logic               sampleClkRunning,
	input wire acp_pkg::acpPower_t powerState,
	input wire acp_pkg::acpMode_t  modeState
);
	int   bitCnt;
	int   wakeCnt;
	logic rdFlag;
	always_ff @(posedge shiftClk or posedge serialSelectN) begin
		if (serialSelectN) begin
			bitCnt <= 0;
			rdFlag <= 1'b0;
		end else begin
			bitCnt <= (bitCnt == 24) ? 1 : bitCnt + 1;
			if (bitCnt % 24 == 0)
				rdFlag <= serialDataIn;
		end
	end
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn)
			wakeCnt <= 0;
		else if (powerState.refOff)
			wakeCnt <= 0;
		else if (wakeCnt < REF_WAKE_CYCLES)
			wakeCnt <= wakeCnt + 1;
	end
	a_oe_read_window: assert property (
		@(negedge shiftClk) disable iff (!resetn || serialSelectN)
		serialDataOe == (rdFlag && bitCnt > 16))
		else $error("data pin drive outside read data bits");
	a_oe_needs_select: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		serialSelectN |-> !serialDataOe)
		else $error("data pin driven while deselected");
	a_pin_powers_adc: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(sampleClkRunning && powerdownSyncPin)[*5] |-> powerState.adcOff)
		else $error("core not down under global request");
	a_frozen_power: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(!sampleClkRunning)[*4] |=>
		$stable({powerState.adcOff, powerState.refOff}))
		else $error("power changed without sampling clock");
	a_ready_after_wake: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		$rose(powerState.refReady) |-> wakeCnt >= REF_WAKE_CYCLES)
		else $error("reference ready too early");
	a_ready_needs_ref: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		powerState.refOff[*2] |-> !powerState.refReady)
		else $error("reference ready while off");
	a_reset_defaults: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		$rose(resetn) |-> modeState.ddcBypass && !modeState.ddrOut &&
		!modeState.offsetBinary && !powerState.adcOff &&
		!modeState.refInternal)
		else $error("defaults wrong after reset");
	a_ext_ref_off: assert property (
		@(posedge sys_clk) disable iff (!resetn)
		(sampleClkRunning && !modeState.refInternal)[*5] |->
		powerState.refOff)
		else $error("internal reference on with external choice");
endmodule
bind acp_config_port acp_config_port_chk #(
	.REF_WAKE_CYCLES(REF_WAKE_CYCLES)
) u_chk (.sys_clk(sys_clk), .resetn(resetn), .shiftClk(shiftClk),
	.serialSelectN(serialSelectN), .serialDataIn(serialDataIn),
	.serialDataOe(serialDataOe), .powerdownSyncPin(powerdownSyncPin),
	.sampleClkRunning(sampleClkRunning), .powerState(powerState),
	.modeState(modeState));

// File: verif/acp_config_port_tb_top.sv
// Self-checking bench for the configuration port.
// Assumes the package compiles first; strap starts at the top code.
`timescale 1ns/1ps
module acp_config_port_tb_top;
	logic               sys_clk = 1'b0;
	logic               resetn = 1'b0;
	logic [7:0]         regAddr = 8'h00;
	logic [31:0]        regWrData = 32'h0;
	logic               regWr = 1'b0;
	logic               regRd = 1'b0;
	logic               powerdownSyncPin = 1'b0;
	logic               sampleClkRunning = 1'b1;
	logic               clkEn = 1'b1;
	logic [1:0]         strap = 2'h3;
	logic [31:0]        regRdData;
	logic               shiftClk, serialSelectN, serialDataIn;
	logic               serialDataOut, serialDataOe;
	acp_pkg::acpPower_t powerState;
	acp_pkg::acpMode_t  modeState;
	int                 n_fail = 0, n_compared = 0, nWr = 0, run = 1;
	int                 pinM = 0, ctrlM = 0, pdnM = 0, refM = 0, fmtM = 0;
	always #10 sys_clk = ~sys_clk;
	acp_config_port #(.REF_WAKE_CYCLES(20)) u_dut (.sys_clk(sys_clk),
		.resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
		.regWrData(regWrData), .regWr(regWr), .regRd(regRd),
		.regRdData(regRdData), .shiftClk(shiftClk),
		.serialSelectN(serialSelectN), .serialDataIn(serialDataIn),
		.serialDataOut(serialDataOut), .serialDataOe(serialDataOe),
		.powerdownSyncPin(powerdownSyncPin), .referenceStrapPin(strap),
		.sampleClkRunning(sampleClkRunning), .powerState(powerState),
		.modeState(modeState));
	acp_host_model u_host (.serialDataOut(serialDataOut),
		.serialDataOe(serialDataOe), .shiftClk(shiftClk),
		.serialSelectN(serialSelectN), .serialDataIn(serialDataIn));
	function automatic logic [31:0] st(input logic rdy);
		logic g;
		logic ri;
		g = pinM[0] | pdnM[0] | ctrlM[0];
		ri = refM[1] ? refM[0] : strap < 2'h2;
		return {24'h0, strap, run[0], rdy, pdnM[5], pdnM[4],
			(g & ~refM[2]) | ~ri, g | pdnM[2]};
	endfunction
	task automatic summarize();
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string w, input logic [31:0] e,
		input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
	endtask
	task automatic busWr(input logic [7:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge sys_clk);
		regWr <= 1'b0;
	endtask
	task automatic rdChk(input string w, input logic [7:0] a,
		input logic [31:0] e);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge sys_clk);
		regRd <= 1'b0;
		#1 chk(w, e, regRdData);
	endtask
	initial begin
		logic [7:0] v;
		logic [7:0] r;
		logic [31:0] e;
		void'($urandom(81095));
		idle(10);
		resetn <= 1'b1;
		idle(8);
		rdChk("status", acp_pkg::LA_STATUS, st(0));
		chk("mode", 32'h04, 32'(modeState));
		v = 8'($urandom) & 8'h07;
		u_host.xfer({24'h0, 4'h0, acp_pkg::SA_FMT, v}, 24, r);
		fmtM = v;
		nWr++;
		idle(6);
		rdChk("fmt", acp_pkg::LA_FMT, fmtM);
		chk("mode", {29'h0, ~v[0], v[1], v[2]}, 32'(modeState));
		u_host.xfer({24'h0, 4'h8, acp_pkg::SA_FMT, ~v}, 24, r);
		idle(6);
		chk("serial read", fmtM, 32'(r));
		rdChk("fmt", acp_pkg::LA_FMT, fmtM);
		u_host.xfer({24'h0, 4'h0, acp_pkg::SA_FMT, ~v} >> 4, 20, r);
		idle(6);
		rdChk("fmt", acp_pkg::LA_FMT, fmtM);
		u_host.xfer({4'h0, acp_pkg::SA_REF, 8'h03, 16'h0fff,
			8'($urandom)}, 48, r);
		refM = 3;
		nWr += 2;
		idle(6);
		rdChk("ref", acp_pkg::LA_REF, refM);
		chk("internal", 32'h1, 32'(modeState.refInternal));
		for (int i = 0; i < 100 && powerState.refReady !== 1'b1; i++)
			idle(1);
		chk("refReady", 32'h1, 32'(powerState.refReady));
		if (powerState.refReady !== 1'b1)
			summarize();
		rdChk("status", acp_pkg::LA_STATUS, st(1));
		rdChk("frames", acp_pkg::LA_FRAMES, nWr);
		powerdownSyncPin <= 1'b1;
		pinM = 1;
		idle(8);
		rdChk("status", acp_pkg::LA_STATUS, st(0));
		sampleClkRunning <= 1'b0;
		run = 0;
		idle(4);
		powerdownSyncPin <= 1'b0;
		idle(8);
		rdChk("status", acp_pkg::LA_STATUS, st(0));
		sampleClkRunning <= 1'b1;
		run = 1;
		pinM = 0;
		idle(8);
		rdChk("status", acp_pkg::LA_STATUS, st(0));
		u_host.xfer({24'h0, 4'h0, acp_pkg::SA_REF, 8'h07}, 24, r);
		refM = 7;
		idle(6);
		busWr(acp_pkg::LA_CTRL, 32'h1);
		ctrlM = 1;
		idle(8);
		rdChk("status", acp_pkg::LA_STATUS, st(1));
		rdChk("ctrl", acp_pkg::LA_CTRL, ctrlM);
		busWr(acp_pkg::LA_PDN, 32'hff);
		rdChk("pdn", acp_pkg::LA_PDN, pdnM);
		rdChk("unmapped", 8'hfc, 32'h0);
		// A write while the enable is low must be lost
		idle(1);
		clkEn <= 1'b0;
		busWr(acp_pkg::LA_CTRL, 32'h0);
		clkEn <= 1'b1;
		rdChk("ctrl", acp_pkg::LA_CTRL, ctrlM);
		// Gain amplifier and clock buffer off, by their own bits whatever the global request
		v = 8'($urandom) | 8'h30;
		u_host.xfer({24'h0, 4'h0, acp_pkg::SA_PDN, v}, 24, r);
		pdnM = v;
		idle(6);
		rdChk("pdn", acp_pkg::LA_PDN, pdnM);
		rdChk("status", acp_pkg::LA_STATUS, st(1));
		// Every strap code, each caught after a fresh reset
		pdnM = 0;
		refM = 0;
		fmtM = 0;
		ctrlM = 0;
		for (int c = 0; c < 4; c++) begin
			resetn <= 1'b0;
			strap <= 2'(c);
			idle(3);
			resetn <= 1'b1;
			idle(8);
			rdChk("status", acp_pkg::LA_STATUS, st(0));
			e = {25'h0, strap < 2'h2, strap == 2'h2,
				strap == 2'h0, strap == 2'h0, 3'h4};
			chk("mode", e, 32'(modeState));
		end
		summarize();
	end
endmodule
